// File: shared/iom_pkg.sv
package iom_pkg;
    // Port widths, 27 lines in all
    localparam int unsigned PA_W = 8;
    localparam int unsigned PB_W = 8;
    localparam int unsigned PC_W = 6;
    localparam int unsigned PD_W = 5;
    // Write select codes
    localparam logic [2:0] SEL_A_DIR = 3'h0;
    localparam logic [2:0] SEL_A_VAL = 3'h1;
    localparam logic [2:0] SEL_B_DIR = 3'h2;
    localparam logic [2:0] SEL_B_VAL = 3'h3;
    localparam logic [2:0] SEL_C_DIR = 3'h4;
    localparam logic [2:0] SEL_C_VAL = 3'h5;
    localparam logic [2:0] SEL_D_DIR = 3'h6;
    localparam logic [2:0] SEL_D_VAL = 3'h7;
    // Reset values: all lines input, data clear
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] VAL_RST = 8'h00;
    // Wake edge history starts high, so an armed line low out of reset counts as a falling edge
    localparam logic [7:0] HIST_RST = 8'hFF;
    // Alternate function bit positions
    localparam int unsigned PB_FLYBACK = 0;
    localparam int unsigned PC_COMPARE = 0;
    localparam int unsigned PC_SPI_LO = 2;
    localparam int unsigned PC_SPI_W = 4;
    localparam int unsigned PD_CSYNC = 0;
    localparam int unsigned PD_HSYNC = 1;
    localparam int unsigned PD_VSYNC = 2;
    localparam int unsigned PD_CLAMP = 3;
endpackage : iom_pkg

// File: rtl/iom_io_port_alternate_function_mux.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Low reset pin requests whole-chip reset
// [R2] Watchdog drives reset pin low
// [R3] Option bit puts timer compare on port C bit 0
// [R4] Enabled SPI owns port C bits 2..5
// [R5] Twenty-seven lines, direction and data per port
// [R6] Port A: plain input or open-drain
// [R7] Port B: analog, pull-up input, push-pull, wake
// [R8] Wake lines: falling edge or low level
// [R9] Pincushion use makes port B bit 0 flyback
// [R10] Port C: input, open-drain or SPI
// [R11] SPI pins drive push-pull while active
// [R12] One bit enables all port C pull-ups
// [R13] SPI enable removes SPI pin pull-ups
// [R14] Port D: pull-up input, push-pull, sync
// [R15] Port D bit 0 takes composite sync
// [R16] Port D bit 1 outputs horizontal sync
// [R17] Port D bit 2 outputs vertical sync
// [R18] Port D bit 3 outputs clamp pulse
// [R19] Port D inputs readable; capture takes the dedicated sync pins
// [R20] Board holds test pin low
// [R21] Direction bit set means output; reset clears
module iom_io_port_alternate_function_mux (
    input wire logic clk_sys,
    input wire logic rstn,
    // Software write port
    input wire logic reg_wr,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    // Configuration bits
    input wire logic compare_sel,
    input wire logic spi_en,
    input wire logic pc_pullup_en,
    input wire logic sync_io_en,
    input wire logic hsync_gen_sel,
    input wire logic vsync_gen_sel,
    input wire logic pincushion_en,
    input wire logic [7:0] pb_analog_sel,
    input wire logic [7:0] pb_wake_en,
    input wire logic pb_wake_level,
    input wire logic [7:0] wake_clr,
    // Internal sources
    input wire logic timer_compare_out,
    input wire logic [3:0] spi_out,
    input wire logic [3:0] spi_oe,
    input wire logic sp_hsync_gen,
    input wire logic sp_vsync_gen,
    input wire logic sp_clamp,
    input wire logic watchdog_fire,
    // Reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic reset_req,
    // Sync pins without port function
    input wire logic horizontal_sync_in,
    input wire logic vertical_sync_in,
    // Port A
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pa_rd,
    // Port B
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    output logic [7:0] pb_pu,
    output logic [7:0] pb_rd,
    // Port C
    input wire logic [5:0] pc_in,
    output logic [5:0] pc_out,
    output logic [5:0] pc_oe,
    output logic [5:0] pc_pu,
    output logic [5:0] pc_rd,
    // Port D
    input wire logic [4:0] pd_in,
    output logic [4:0] pd_out,
    output logic [4:0] pd_oe,
    output logic [4:0] pd_pu,
    output logic [4:0] pd_rd,
    // To other blocks
    output logic [7:0] wake_flag,
    output logic wake_req,
    output logic vertical_flyback_in,
    output logic composite_sync_in,
    output logic cap_hsync,
    output logic cap_vsync,
    output logic [3:0] spi_in
);

////////////////////////////////////////////////////////////////////////
// State

    // Whole module state in one word
    typedef struct packed {
        logic [7:0] a_dir;
        logic [7:0] a_val;
        logic [7:0] a_out;
        logic [7:0] a_oe;
        logic [7:0] a_rd;
        logic [7:0] b_dir;
        logic [7:0] b_val;
        logic [7:0] b_out;
        logic [7:0] b_oe;
        logic [7:0] b_pu;
        logic [7:0] b_rd;
        logic [7:0] b_prev;
        logic [7:0] wake;
        logic wake_any;
        logic [5:0] c_dir;
        logic [5:0] c_val;
        logic [5:0] c_out;
        logic [5:0] c_oe;
        logic [5:0] c_pu;
        logic [5:0] c_rd;
        logic [4:0] d_dir;
        logic [4:0] d_val;
        logic [4:0] d_out;
        logic [4:0] d_oe;
        logic [4:0] d_pu;
        logic [4:0] d_rd;
        logic rst_req;
        logic rst_oe;
        logic flyback;
        logic csync;
        logic cap_h;
        logic cap_v;
        logic [3:0] spi_in;
    } iom_state_t;

    iom_state_t s_q; // Registered state
    iom_state_t s_d; // Next state

    // Edge and level wake sources
    logic [7:0] wake_hit;
    // Lines armed for wake
    logic [7:0] wake_arm;

////////////////////////////////////////////////////////////////////////
// Next state

    // All muxing in one pass; outputs follow the new register values
    always_comb begin
        s_d = s_q;
        // Register writes; direction 1 means output
        if (reg_wr) begin // [R5]
            unique case (reg_sel)
                iom_pkg::SEL_A_DIR: s_d.a_dir = reg_wdata; // [R21]
                iom_pkg::SEL_A_VAL: s_d.a_val = reg_wdata;
                iom_pkg::SEL_B_DIR: s_d.b_dir = reg_wdata; // [R21]
                iom_pkg::SEL_B_VAL: s_d.b_val = reg_wdata;
                iom_pkg::SEL_C_DIR: s_d.c_dir = reg_wdata[5:0];
                iom_pkg::SEL_C_VAL: s_d.c_val = reg_wdata[5:0];
                iom_pkg::SEL_D_DIR: s_d.d_dir = reg_wdata[4:0];
                iom_pkg::SEL_D_VAL: s_d.d_val = reg_wdata[4:0];
            endcase
        end

        // Port A: open drain only pulls low, never drives high
        s_d.a_out = '0; // [R6]
        s_d.a_oe = s_d.a_dir & ~s_d.a_val; // [R6]
        s_d.a_rd = (s_d.a_dir & s_d.a_val) | (~s_d.a_dir & pa_in);

        // Port B: push-pull, pull-up on digital inputs
        s_d.b_out = s_d.b_val;
        s_d.b_oe = s_d.b_dir & ~pb_analog_sel; // [R7]
        s_d.b_pu = ~s_d.b_dir & ~pb_analog_sel; // [R7]
        if (pincushion_en) begin
            // Flyback is a TTL input; no drive, no pull-up
            s_d.b_oe[iom_pkg::PB_FLYBACK] = 1'b0; // [R9]
            s_d.b_pu[iom_pkg::PB_FLYBACK] = 1'b0; // [R9]
        end
        s_d.b_rd = (s_d.b_dir & s_d.b_val) | (~s_d.b_dir & pb_in);
        s_d.flyback = pincushion_en & pb_in[iom_pkg::PB_FLYBACK]; // [R9]

        // Wake: sticky flags, a new hit beats a clear
        s_d.b_prev = pb_in;
        wake_arm = pb_wake_en & ~s_d.b_dir;
        if (pb_wake_level) begin
            wake_hit = wake_arm & ~pb_in; // [R8]
        end else begin
            wake_hit = wake_arm & s_q.b_prev & ~pb_in; // [R8]
        end
        s_d.wake = (s_q.wake & ~wake_clr) | wake_hit; // [R8]
        s_d.wake_any = |s_d.wake; // [R8]

        // Port C: open drain by default
        s_d.c_out = '0;
        s_d.c_oe = s_d.c_dir & ~s_d.c_val; // [R10]
        s_d.c_pu = pc_pullup_en ? ~s_d.c_dir : '0; // [R12]
        if (compare_sel) begin
            // Timer compare drives the pin both ways
            s_d.c_out[iom_pkg::PC_COMPARE] = timer_compare_out; // [R3]
            s_d.c_oe[iom_pkg::PC_COMPARE] = 1'b1; // [R3]
            s_d.c_pu[iom_pkg::PC_COMPARE] = 1'b0;
        end
        if (spi_en) begin
            // SPI owns direction; outputs are push-pull
            s_d.c_out[5:2] = spi_out; // [R4]
            s_d.c_oe[5:2] = spi_oe; // [R11]
            s_d.c_pu[5:2] = 4'h0; // [R13]
        end
        s_d.c_rd = (s_d.c_dir & s_d.c_val) | (~s_d.c_dir & pc_in);
        // SPI sees pin levels only while enabled
        s_d.spi_in = spi_en ? pc_in[5:2] : 4'h0; // [R4]

        // Port D: push-pull, pull-up on inputs
        s_d.d_out = s_d.d_val; // [R14]
        s_d.d_oe = s_d.d_dir; // [R14]
        s_d.d_pu = ~s_d.d_dir; // [R14]
        if (sync_io_en) begin
            s_d.d_oe[iom_pkg::PD_CSYNC] = 1'b0; // [R15]
            s_d.d_pu[iom_pkg::PD_CSYNC] = 1'b0; // [R15]
            s_d.d_out[iom_pkg::PD_HSYNC] =
                hsync_gen_sel ? sp_hsync_gen : horizontal_sync_in; // [R16]
            s_d.d_out[iom_pkg::PD_VSYNC] =
                vsync_gen_sel ? sp_vsync_gen : vertical_sync_in; // [R17]
            s_d.d_out[iom_pkg::PD_CLAMP] = sp_clamp; // [R18]
            s_d.d_oe[3:1] = 3'h7; // [R16]
            s_d.d_pu[3:1] = 3'h0;
        end
        // Inputs read raw pin levels, so sync can be inspected
        s_d.d_rd = (s_d.d_dir & s_d.d_val) | (~s_d.d_dir & pd_in); // [R19]
        s_d.csync = sync_io_en & pd_in[iom_pkg::PD_CSYNC]; // [R15]
        // Capture path takes the raw sync pins
        s_d.cap_h = horizontal_sync_in; // [R19]
        s_d.cap_v = vertical_sync_in; // [R19]

        // Reset pin: low in means reset; watchdog pulls it low
        s_d.rst_req = ~reset_pin_in; // [R1]
        s_d.rst_oe = watchdog_fire; // [R2]
    end

////////////////////////////////////////////////////////////////////////
// Registers

    // Async reset to constants: all lines input, data clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0; // [R21]
            s_q.a_dir <= iom_pkg::DIR_RST; // [R21]
            s_q.b_dir <= iom_pkg::DIR_RST;
            s_q.c_dir <= iom_pkg::DIR_RST[5:0];
            s_q.d_dir <= iom_pkg::DIR_RST[4:0];
            s_q.a_val <= iom_pkg::VAL_RST;
            s_q.b_val <= iom_pkg::VAL_RST;
            s_q.b_prev <= iom_pkg::HIST_RST;
            // Reset request is asserted while the chip is held in reset
            s_q.rst_req <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

////////////////////////////////////////////////////////////////////////
// Outputs

    // Every output but reset_pin_out is a state flop; the test pin stays off-chip
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = s_q.rst_oe;
    assign reset_req = s_q.rst_req;
    assign pa_out = s_q.a_out;
    assign pa_oe = s_q.a_oe;
    assign pa_rd = s_q.a_rd;
    assign pb_out = s_q.b_out;
    assign pb_oe = s_q.b_oe;
    assign pb_pu = s_q.b_pu;
    assign pb_rd = s_q.b_rd;
    assign pc_out = s_q.c_out;
    assign pc_oe = s_q.c_oe;
    assign pc_pu = s_q.c_pu;
    assign pc_rd = s_q.c_rd;
    assign pd_out = s_q.d_out;
    assign pd_oe = s_q.d_oe;
    assign pd_pu = s_q.d_pu;
    assign pd_rd = s_q.d_rd;
    assign wake_flag = s_q.wake;
    assign wake_req = s_q.wake_any;
    assign vertical_flyback_in = s_q.flyback;
    assign composite_sync_in = s_q.csync;
    assign cap_hsync = s_q.cap_h;
    assign cap_vsync = s_q.cap_v;
    assign spi_in = s_q.spi_in;

////////////////////////////////////////////////////////////////////////
// Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_rst_req;
        !reset_pin_in |=> reset_req;
    endproperty
    a_rst_req: assert property (p_rst_req) // [R1]
        else $error("reset pin low not seen");
    property p_wdog;
        watchdog_fire |=> reset_pin_oe && !reset_pin_out;
    endproperty
    a_wdog: assert property (p_wdog) // [R2]
        else $error("watchdog did not pull reset pin");
    property p_compare;
        compare_sel |=> pc_oe[0] && pc_out[0] == $past(timer_compare_out);
    endproperty
    a_compare: assert property (p_compare) // [R3]
        else $error("compare output not on port C bit 0");
    property p_spi_drive;
        spi_en |=> pc_oe[5:2] == $past(spi_oe) &&
            pc_out[5:2] == $past(spi_out);
    endproperty
    a_spi_drive: assert property (p_spi_drive) // [R11]
        else $error("SPI pins not driven push-pull");
    property p_spi_pu;
        spi_en |=> pc_pu[5:2] == 4'h0;
    endproperty
    a_spi_pu: assert property (p_spi_pu) // [R13]
        else $error("pull-up left on SPI pin");
    property p_pc_pu_off;
        !pc_pullup_en |=> pc_pu == 6'h00;
    endproperty
    a_pc_pu_off: assert property (p_pc_pu_off) // [R12]
        else $error("port C pull-up without enable");
    property p_dir_a;
        reg_wr && reg_sel == iom_pkg::SEL_A_DIR |=>
            pa_oe == ($past(reg_wdata) & ~s_q.a_val) && pa_out == 8'h00;
    endproperty
    a_dir_a: assert property (p_dir_a) // [R6]
        else $error("port A open-drain drive wrong");
    // Armed low line in level mode flags on the very next edge
    property p_wake_lvl;
        pb_wake_level && !reg_wr &&
            |(pb_wake_en & ~s_q.b_dir & ~pb_in) |=> wake_req;
    endproperty
    a_wake_lvl: assert property (p_wake_lvl) // [R8]
        else $error("low wake line not flagged");
    property p_flyback;
        pincushion_en |=> !pb_oe[0] &&
            vertical_flyback_in == $past(pb_in[0]);
    endproperty
    a_flyback: assert property (p_flyback) // [R9]
        else $error("flyback input not taken on port B bit 0");
    property p_csync;
        sync_io_en |=> !pd_oe[0] &&
            composite_sync_in == $past(pd_in[0]);
    endproperty
    a_csync: assert property (p_csync) // [R15]
        else $error("composite sync not taken on port D bit 0");
    property p_hsync;
        sync_io_en && hsync_gen_sel |=>
            pd_oe[1] && pd_out[1] == $past(sp_hsync_gen);
    endproperty
    a_hsync: assert property (p_hsync) // [R16]
        else $error("horizontal sync not on port D bit 1");
    property p_vsync;
        sync_io_en && !vsync_gen_sel |=>
            pd_oe[2] && pd_out[2] == $past(vertical_sync_in);
    endproperty
    a_vsync: assert property (p_vsync) // [R17]
        else $error("vertical sync not on port D bit 2");
    property p_clamp;
        sync_io_en |=> pd_oe[3] && pd_out[3] == $past(sp_clamp);
    endproperty
    a_clamp: assert property (p_clamp) // [R18]
        else $error("clamp pulse not on port D bit 3");

endmodule : iom_io_port_alternate_function_mux

// File: tb/iom_board_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Board around the chip: strong external sources on port pins,
// a pull-up on the reset line, the test pin strapped low
module iom_board_model (
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    input wire logic [5:0] pc_out,
    input wire logic [5:0] pc_oe,
    input wire logic [4:0] pd_out,
    input wire logic [4:0] pd_oe,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [5:0] ext_c,
    input wire logic [4:0] ext_d,
    input wire logic ext_rst_n,
    output logic [7:0] pa_in,
    output logic [7:0] pb_in,
    output logic [5:0] pc_in,
    output logic [4:0] pd_in,
    output logic reset_pin_in
);
    // Never driven away from ground on this board
    localparam logic TEST_PIN = 1'b0;
    // Chip drive wins where enabled, board level elsewhere
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
    // Pull-up holds reset high unless someone sinks it
    assign reset_pin_in = reset_pin_oe ? reset_pin_out : ext_rst_n;
endmodule : iom_board_model

// File: tb/testbench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module testbench;
    logic clk_sys, rstn, reg_wr, compare_sel, spi_en, pc_pullup_en;
    logic sync_io_en, hsync_gen_sel, vsync_gen_sel, pincushion_en;
    logic pb_wake_level, timer_compare_out, sp_hsync_gen, sp_vsync_gen;
    logic sp_clamp, watchdog_fire, horizontal_sync_in, vertical_sync_in;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, reset_req, wake_req;
    logic vertical_flyback_in, composite_sync_in, cap_hsync, cap_vsync;
    logic ext_rst_n;
    logic [2:0] reg_sel;
    logic [3:0] spi_out, spi_oe, spi_in;
    logic [4:0] pd_in, pd_out, pd_oe, pd_pu, pd_rd, ext_d;
    logic [5:0] pc_in, pc_out, pc_oe, pc_pu, pc_rd, ext_c;
    logic [7:0] reg_wdata, pb_analog_sel, pb_wake_en, wake_clr, wake_flag;
    logic [7:0] pa_in, pa_out, pa_oe, pa_rd, ext_a, ext_b;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pb_rd;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    iom_io_port_alternate_function_mux dut (.*);
    iom_board_model board (.*);
    ////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the fewer than a hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // Case inequality so unknowns never match
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // n falling edges; two give registered pin drive, then its read-back
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // One-cycle write strobe, dropped a full cycle later
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
        tick(2);
    endtask : wr
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rstn = 1'b0;
        tick(8);
        chk("reset_req", 8'h01, reset_req);
        chk("pa_oe", 8'h00, pa_oe | pb_oe);
        chk("pcd_oe", 8'h00, pc_oe | pd_oe);
        rstn = 1'b1;
        tick(2);
        chk("reset_req", 8'h00, reset_req);
        // External low on the reset line asks for a reset
        ext_rst_n = 1'b0;
        tick(2);
        chk("reset_req", 8'h01, reset_req);
        ext_rst_n = 1'b1;
        tick(2);
        $display("test reset done");
    endtask : t_reset
    task automatic t_port_a;
        wr(iom_pkg::SEL_A_DIR, 8'hFF);
        wr(iom_pkg::SEL_A_VAL, 8'h0F);
        // Open drain: only zero bits sink
        chk("pa_oe", 8'hF0, pa_oe);
        chk("pa_out", 8'h00, pa_out);
        chk("pa_rd", 8'h0F, pa_rd);
        wr(iom_pkg::SEL_A_DIR, 8'h00);
        chk("pa_oe", 8'h00, pa_oe);
        chk("pa_rd", ext_a, pa_rd);
        $display("test port_a done");
    endtask : t_port_a
    task automatic t_port_b;
        pb_analog_sel = 8'h80;
        wr(iom_pkg::SEL_B_DIR, 8'h0F);
        wr(iom_pkg::SEL_B_VAL, 8'h05);
        chk("pb_oe", 8'h0F, pb_oe);
        chk("pb_out", 8'h05, pb_out & 8'h0F);
        chk("pb_pu", 8'h70, pb_pu);
        chk("pb_rd", 8'h75, pb_rd & 8'h7F);
        // Bit 1 is an output, so its wake stays disarmed
        pb_wake_en = 8'h02;
        ext_b = 8'hF5;
        tick(2);
        chk("wake_flag", 8'h00, wake_flag);
        ext_b = 8'hFF;
        wr(iom_pkg::SEL_B_DIR, 8'h00);
        // Falling edge on bit 1; bit 3 low but not enabled
        ext_b = 8'hF5;
        tick(2);
        chk("wake_flag", 8'h02, wake_flag);
        chk("wake_req", 8'h01, wake_req);
        wake_clr = 8'h02;
        tick(1);
        wake_clr = 8'h00;
        tick(1);
        chk("wake_flag", 8'h00, wake_flag);
        // Level mode: held low sets it again
        pb_wake_level = 1'b1;
        tick(2);
        chk("wake_flag", 8'h02, wake_flag);
        ext_b = 8'hFF;
        pb_wake_level = 1'b0;
        wake_clr = 8'h02;
        tick(1);
        wake_clr = 8'h00;
        tick(1);
        chk("wake_req", 8'h00, wake_req);
        $display("test port_b done");
    endtask : t_port_b
    task automatic t_flyback;
        pincushion_en = 1'b1;
        wr(iom_pkg::SEL_B_DIR, 8'h01);
        chk("pb_oe", 8'h00, pb_oe);
        chk("flyback", 8'h01, vertical_flyback_in);
        ext_b = 8'hFE;
        tick(2);
        chk("flyback", 8'h00, vertical_flyback_in);
        pincushion_en = 1'b0;
        ext_b = 8'hFF;
        tick(2);
        chk("flyback", 8'h00, vertical_flyback_in);
        chk("pb_oe", 8'h01, pb_oe);
        $display("test flyback done");
    endtask : t_flyback
    task automatic t_port_c;
        pc_pullup_en = 1'b1;
        wr(iom_pkg::SEL_C_DIR, 8'h3F);
        wr(iom_pkg::SEL_C_VAL, 8'h3E);
        chk("pc_oe", 8'h01, pc_oe);
        chk("pc_out", 8'h00, pc_out);
        chk("pc_rd", 8'h3E, pc_rd);
        wr(iom_pkg::SEL_C_DIR, 8'h00);
        chk("pc_pu", 8'h3F, pc_pu);
        // SPI takes bits 2..5 push-pull, no pull-up there
        spi_en = 1'b1;
        spi_oe = 4'hF;
        spi_out = 4'h5;
        tick(2);
        chk("pc_oe", 8'h3C, pc_oe);
        chk("pc_out", 8'h14, pc_out & 6'h3C);
        chk("pc_pu", 8'h03, pc_pu);
        compare_sel = 1'b1;
        timer_compare_out = 1'b1;
        tick(2);
        chk("pc_oe", 8'h3D, pc_oe);
        chk("pc_out", 8'h15, pc_out & 6'h3D);
        spi_oe = 4'h0;
        ext_c = 6'h28;
        tick(2);
        chk("spi_in", 8'h0A, spi_in);
        spi_en = 1'b0;
        compare_sel = 1'b0;
        tick(2);
        chk("spi_in", 8'h00, spi_in);
        chk("pc_pu", 8'h3F, pc_pu);
        $display("test port_c done");
    endtask : t_port_c
    task automatic t_port_d;
        wr(iom_pkg::SEL_D_DIR, 8'h1F);
        wr(iom_pkg::SEL_D_VAL, 8'h0A);
        chk("pd_oe", 8'h1F, pd_oe);
        chk("pd_out", 8'h0A, pd_out);
        wr(iom_pkg::SEL_D_DIR, 8'h00);
        chk("pd_pu", 8'h1F, pd_pu);
        chk("pd_rd", 8'h15, pd_rd);
        // Generated hsync, pass-through vsync, clamp high
        sync_io_en = 1'b1;
        hsync_gen_sel = 1'b1;
        sp_hsync_gen = 1'b1;
        vertical_sync_in = 1'b1;
        sp_clamp = 1'b1;
        tick(2);
        chk("csync", 8'h01, composite_sync_in);
        chk("pd_oe", 8'h0E, pd_oe & 5'h0F);
        chk("pd_out", 8'h0E, pd_out & 5'h0E);
        chk("cap", 8'h01, {cap_hsync, cap_vsync});
        // Swap sources so every bit must fall
        hsync_gen_sel = 1'b0;
        vsync_gen_sel = 1'b1;
        sp_vsync_gen = 1'b0;
        sp_clamp = 1'b0;
        tick(2);
        chk("pd_out", 8'h00, pd_out & 5'h0E);
        horizontal_sync_in = 1'b1;
        vertical_sync_in = 1'b0;
        sp_hsync_gen = 1'b0;
        tick(2);
        chk("pd_out", 8'h02, pd_out & 5'h0E);
        chk("cap", 8'h02, {cap_hsync, cap_vsync});
        sync_io_en = 1'b0;
        tick(2);
        chk("csync", 8'h00, composite_sync_in);
        chk("pd_oe", 8'h00, pd_oe);
        $display("test port_d done");
    endtask : t_port_d
    task automatic t_watchdog;
        watchdog_fire = 1'b1;
        tick(3);
        chk("rst_oe", 8'h01, reset_pin_oe);
        chk("rst_out", 8'h00, reset_pin_out);
        chk("reset_req", 8'h01, reset_req);
        watchdog_fire = 1'b0;
        tick(3);
        chk("rst_oe", 8'h00, reset_pin_oe);
        chk("reset_req", 8'h00, reset_req);
        $display("test watchdog done");
    endtask : t_watchdog
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reg_wr, compare_sel, spi_en, pc_pullup_en, sync_io_en} = '0;
        {hsync_gen_sel, vsync_gen_sel, pincushion_en, pb_wake_level} = '0;
        {timer_compare_out, sp_hsync_gen, sp_vsync_gen, sp_clamp} = '0;
        {watchdog_fire, horizontal_sync_in, vertical_sync_in} = '0;
        {reg_sel, reg_wdata, spi_out, spi_oe, wake_clr} = '0;
        {pb_analog_sel, pb_wake_en} = '0;
        ext_rst_n = 1'b1;
        ext_a = 8'hA5;
        ext_b = 8'hFF;
        ext_c = 6'h3F;
        ext_d = 5'h15;
        rstn = 1'b0;
        t_reset();
        t_port_a();
        t_port_b();
        t_flyback();
        t_port_c();
        t_port_d();
        t_watchdog();
        close_out();
    end
endmodule : testbench
